/* smprc_pkg.sv */
package smprc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int        NUM_CS      = 6;
    localparam logic [7:0] OFS_SETUP   = 8'h00;
    localparam logic [7:0] OFS_PULSE   = 8'h04;
    localparam logic [7:0] OFS_CYCLE   = 8'h08;
    localparam logic [7:0] OFS_MODE    = 8'h0c;
    localparam logic [7:0] CS_STRIDE   = 8'h10;
    localparam logic [7:0] CS_AREA_END = 8'h60;
    localparam logic [7:0] OFS_WPMR    = 8'he4;
    localparam logic [7:0] OFS_WPSR    = 8'he8;
    localparam logic [1:0] IDX_SETUP   = 2'd0;
    localparam logic [1:0] IDX_PULSE   = 2'd1;
    localparam logic [1:0] IDX_CYCLE   = 2'd2;
    localparam logic [1:0] IDX_MODE    = 2'd3;

    // Reset values
    localparam logic [31:0] RST_SETUP = 32'h01010101;
    localparam logic [31:0] RST_PULSE = 32'h01010101;
    localparam logic [31:0] RST_CYCLE = 32'h00030003;
    localparam logic [31:0] RST_MODE  = 32'h10001000;

    // Field positions in setup, pulse and cycle registers
    localparam int POS_WR_STB = 0;
    localparam int POS_CS_WR  = 8;
    localparam int POS_RD_STB = 16;
    localparam int POS_CS_RD  = 24;

    // Field positions in mode register
    localparam int         POS_BUS_WIDTH = 12;
    localparam int         POS_BYTE_ACC  = 8;
    localparam int         POS_PAGE_EN   = 24;
    localparam int         POS_PAGE_SIZE = 28;
    localparam logic [1:0] BUS_W16       = 2'd1;
    localparam logic [1:0] BUS_W32       = 2'd2;

    // Protection registers
    localparam int POS_WP_EN = 0;
    localparam int POS_VIOL  = 0;
    localparam int POS_VSRC  = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {S_IDLE, S_ACC, S_PGOPEN} smprc_state_e;

    typedef struct packed {
        logic        wr;
        logic [2:0]  cs;
        logic [25:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } smprc_req_s;

    typedef struct packed {
        logic [5:0]  chip_select_n;
        logic        read_strobe_n;
        logic        write_strobe_n;
        logic [3:0]  byte_sel_n;
        logic [25:0] addr;
        logic [31:0] wdata;
        logic        data_oe;
    } smprc_pins_s;

    typedef struct packed {
        logic [NUM_CS-1:0][3:0][31:0] cfg;
        logic [NUM_CS-1:0][3:0][31:0] act;
        logic                         write_protect_enable;
        logic                         viol;
        logic [15:0]                  vsrc;
        logic                         ack;
        logic [31:0]                  bus_rdata;
        smprc_state_e                 st;
        logic                         page;
        logic [2:0]                   cs;
        logic                         wr;
        logic [25:0]                  addr;
        logic [3:0]                   be;
        logic [31:0]                  wdata;
        logic [10:0]                  cnt;
        logic [10:0]                  cs_on;
        logic [10:0]                  cs_off;
        logic [10:0]                  st_on;
        logic [10:0]                  st_off;
        logic [10:0]                  t_end;
        logic                         pg_open;
        logic [2:0]                   pg_cs;
        logic [25:0]                  pg_addr;
        logic                         rsp_valid;
        logic [31:0]                  rsp_rdata;
    } smprc_regs_s;

    ////////////////////////////////////////////////////////////////////////////
    // Field decoders, lengths in clock cycles
    function automatic logic [10:0] setup_len(input logic [5:0] f);
        setup_len = {3'h0, f[5], 7'h00} + {6'h00, f[4:0]};
    endfunction

    function automatic logic [10:0] pulse_len(input logic [6:0] f);
        pulse_len = {2'h0, f[6], 8'h00} + {5'h00, f[5:0]};
    endfunction

    function automatic logic [10:0] cycle_len(input logic [8:0] f);
        cycle_len = {1'b0, f[8:7], 8'h00} + {4'h0, f[6:0]};
    endfunction

endpackage

/* smprc_ctrl.sv */
// Design decision made here: the Avalon-MM slave port.
module smprc_ctrl
    import smprc_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        req_valid_i,
    input  smprc_req_s       req_i,
    output logic             req_ready_o,
    input  wire logic        other_access_i,
    output logic             rsp_valid_o,
    output logic      [31:0] rsp_rdata_o,
    input  wire logic [31:0] mem_rdata_i,
    output smprc_pins_s      pins_o
);

    smprc_regs_s q;
    smprc_regs_s d;
    logic        bus_req;
    logic [2:0]  bus_cs;
    logic [1:0]  bus_reg;
    logic [2:0]  cs_sel;
    logic [31:0] a_setup;
    logic [31:0] a_pulse;
    logic [31:0] a_cycle;
    logic [31:0] a_mode;
    logic [31:0] q_mode;
    logic [25:0] off_m;
    logic [25:0] lane_addr;
    logic        pg_rd;
    logic        hit;
    logic        acc;
    logic        cs_low;
    logic        stb_low;
    logic [10:0] first_len;
    logic [10:0] sub_len;
    logic [10:0] rd_cs_setup;
    logic        viol_set;
    logic        viol_clr;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus decode
    assign bus_req           = avs_read_i | avs_write_i;
    assign bus_cs            = avs_address_i[6:4];
    assign bus_reg           = avs_address_i[3:2];
    assign avs_waitrequest_o = bus_req & ~(q.ack & ce_i);
    assign avs_readdata_o    = q.bus_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Active configuration of the requested chip select
    assign cs_sel      = (req_i.cs < 3'(NUM_CS)) ? req_i.cs : 3'd0;
    assign a_setup     = q.act[cs_sel][IDX_SETUP];
    assign a_pulse     = q.act[cs_sel][IDX_PULSE];
    assign a_cycle     = q.act[cs_sel][IDX_CYCLE];
    assign a_mode      = q.act[cs_sel][IDX_MODE];
    assign q_mode      = q.act[(q.cs < 3'(NUM_CS)) ? q.cs : 3'd0][IDX_MODE];
    assign first_len   = pulse_len(a_pulse[POS_CS_RD +: 7]);
    assign sub_len     = pulse_len(a_pulse[POS_RD_STB +: 7]);
    assign rd_cs_setup = setup_len(a_setup[POS_CS_RD +: 6]);

    // Page offset mask from the page size, pages aligned to their size
    assign off_m = 26'((26'd4 << a_mode[POS_PAGE_SIZE +: 2]) - 26'd1);
    assign pg_rd = ~req_i.wr & a_mode[POS_PAGE_EN];

    // Same chip select and same page bits, sequential or not
    assign hit = q.pg_open & (q.pg_cs == req_i.cs)
               & (((q.pg_addr ^ req_i.addr) & ~off_m) == 26'd0);

    // Lane bits below the device width are not driven
    always_comb begin
        lane_addr = req_i.addr;
        if (a_mode[POS_BUS_WIDTH +: 2] == BUS_W16) begin
            lane_addr[0] = 1'b0;
        end else if (a_mode[POS_BUS_WIDTH +: 2] == BUS_W32) begin
            lane_addr[1:0] = 2'b00;
        end
    end

    // Request handshake
    assign req_ready_o = ce_i & ((q.st == S_IDLE)
                       | ((q.st == S_PGOPEN) & hit & pg_rd & ~other_access_i));
    assign acc         = req_valid_i & req_ready_o;

    ////////////////////////////////////////////////////////////////////////////
    // External pins
    assign cs_low  = ((q.st == S_ACC) & (q.cnt >= q.cs_on) & (q.cnt < q.cs_off))
                   | (q.st == S_PGOPEN);
    assign stb_low = ((q.st == S_ACC) & (q.cnt >= q.st_on) & (q.cnt < q.st_off))
                   | (q.st == S_PGOPEN);

    always_comb begin
        pins_o.chip_select_n  = ~(6'(cs_low) << q.cs);
        pins_o.read_strobe_n  = ~(stb_low & ~q.wr);
        pins_o.write_strobe_n = ~(stb_low & q.wr & (q.st == S_ACC));
        pins_o.addr           = q.addr;
        pins_o.wdata          = q.wdata;
        pins_o.data_oe        = q.wr & (q.st == S_ACC);
        // Byte selects follow the byte access type, also in page mode
        if (!cs_low) begin
            pins_o.byte_sel_n = 4'hf;
        end else if (!q_mode[POS_BYTE_ACC]) begin
            pins_o.byte_sel_n = ~q.be;
        end else begin
            pins_o.byte_sel_n = 4'h0;
        end
    end

    assign rsp_valid_o = q.rsp_valid;
    assign rsp_rdata_o = q.rsp_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d           = q;
        d.rsp_valid = 1'b0;
        viol_set    = 1'b0;
        viol_clr    = 1'b0;
        rd_mux      = 32'h0;

        // Read data mux, sampled when a bus request is first seen
        if (avs_address_i < CS_AREA_END) begin
            rd_mux = q.cfg[bus_cs][bus_reg];
        end else if (avs_address_i == OFS_WPMR) begin
            rd_mux[POS_WP_EN] = q.write_protect_enable;
        end else if (avs_address_i == OFS_WPSR) begin
            rd_mux[POS_VIOL]       = q.viol;
            rd_mux[POS_VSRC +: 16] = q.vsrc;
        end
        d.ack = bus_req & ~q.ack;
        if (d.ack) begin
            d.bus_rdata = rd_mux;
        end

        // Register writes on the accepting edge
        if (q.ack && avs_write_i) begin
            if (avs_address_i < CS_AREA_END) begin
                if (q.write_protect_enable) begin
                    viol_set = 1'b1;
                    d.vsrc   = {8'h00, avs_address_i};
                end else begin
                    for (int b = 0; b < 4; b++) begin
                        if (avs_byteenable_i[b]) begin
                            d.cfg[bus_cs][bus_reg][8*b +: 8] = avs_writedata_i[8*b +: 8];
                        end
                    end
                    if (bus_reg == IDX_MODE) begin
                        d.act = d.cfg;
                    end
                end
            end else if (avs_address_i == OFS_WPMR && avs_byteenable_i[0]) begin
                d.write_protect_enable = avs_writedata_i[POS_WP_EN];
            end
        end
        if (q.ack && avs_read_i && avs_address_i == OFS_WPSR) begin
            viol_clr = 1'b1;
        end
        d.viol = (q.viol & ~viol_clr) | viol_set;

        // Access sequencer
        case (q.st)
            S_IDLE: begin
                if (acc) begin
                    d.cnt = 11'd0;
                    if (req_i.cs >= 3'(NUM_CS)) begin
                        d.rsp_valid = 1'b1;
                        d.rsp_rdata = 32'h0;
                    end else begin
                        d.st    = S_ACC;
                        d.cs    = req_i.cs;
                        d.wr    = req_i.wr;
                        d.addr  = lane_addr;
                        d.be    = req_i.be;
                        d.wdata = req_i.wdata;
                        d.page  = pg_rd;
                        if (pg_rd) begin
                            // New page: long first access, setup and cycle unused
                            d.t_end  = first_len;
                            d.cs_on  = 11'd0;
                            d.cs_off = first_len;
                            d.st_on  = 11'd0;
                            d.st_off = first_len;
                        end else if (req_i.wr) begin
                            d.cs_on  = setup_len(a_setup[POS_CS_WR +: 6]);
                            d.cs_off = 11'(d.cs_on + pulse_len(a_pulse[POS_CS_WR +: 7]));
                            d.st_on  = setup_len(a_setup[POS_WR_STB +: 6]);
                            d.st_off = 11'(d.st_on + pulse_len(a_pulse[POS_WR_STB +: 7]));
                            d.t_end  = cycle_len(a_cycle[POS_WR_STB +: 9]);
                        end else begin
                            d.cs_on  = rd_cs_setup;
                            d.cs_off = 11'(rd_cs_setup + first_len);
                            d.st_on  = setup_len(a_setup[POS_RD_STB +: 6]);
                            d.st_off = 11'(d.st_on + sub_len);
                            d.t_end  = cycle_len(a_cycle[POS_RD_STB +: 9]);
                        end
                    end
                end
            end
            S_ACC: begin
                if (11'(q.cnt + 11'd1) >= q.t_end) begin
                    d.rsp_valid = 1'b1;
                    d.cnt       = 11'd0;
                    if (!q.wr) begin
                        d.rsp_rdata = mem_rdata_i;
                    end
                    if (q.page) begin
                        // Hold the page open with chip select and read strobe low
                        d.st      = S_PGOPEN;
                        d.pg_open = 1'b1;
                        d.pg_cs   = q.cs;
                        d.pg_addr = q.addr;
                    end else begin
                        d.st = S_IDLE;
                    end
                end else begin
                    d.cnt = 11'(q.cnt + 11'd1);
                end
            end
            S_PGOPEN: begin
                if (other_access_i) begin
                    d.st      = S_IDLE;
                    d.pg_open = 1'b0;
                end else if (acc) begin
                    // Same page: short access, sequential or not
                    d.st     = S_ACC;
                    d.cnt    = 11'd0;
                    d.addr   = lane_addr;
                    d.be     = req_i.be;
                    d.t_end  = sub_len;
                    d.cs_on  = 11'd0;
                    d.cs_off = sub_len;
                    d.st_on  = 11'd0;
                    d.st_off = sub_len;
                end else if (req_valid_i) begin
                    // Page break: release chip select, restart from idle
                    d.st      = S_IDLE;
                    d.pg_open = 1'b0;
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, frozen while the clock enable is low
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q    <= '0;
            q.st <= S_IDLE;
            for (int c = 0; c < NUM_CS; c++) begin
                q.cfg[c][IDX_SETUP] <= RST_SETUP;
                q.cfg[c][IDX_PULSE] <= RST_PULSE;
                q.cfg[c][IDX_CYCLE] <= RST_CYCLE;
                q.cfg[c][IDX_MODE]  <= RST_MODE;
                q.act[c][IDX_SETUP] <= RST_SETUP;
                q.act[c][IDX_PULSE] <= RST_PULSE;
                q.act[c][IDX_CYCLE] <= RST_CYCLE;
                q.act[c][IDX_MODE]  <= RST_MODE;
            end
        end else if (ce_i) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_page_strobes: assert property (
        (q.st == S_ACC && q.page) |-> (cs_low && !pins_o.read_strobe_n
                                       && pins_o.write_strobe_n))
        else $error("page read strobes not low together");

    chk_first_len: assert property (
        (ce_i && acc && q.st == S_IDLE && pg_rd && req_i.cs < 3'(NUM_CS))
        |=> (q.t_end == $past(first_len) && q.cs_on == 11'd0 && q.page))
        else $error("first page access length wrong");

    chk_hit_len: assert property (
        (ce_i && acc && q.st == S_PGOPEN)
        |=> (q.st == S_ACC && q.t_end == $past(sub_len) && cs_low))
        else $error("same page access not short");

    chk_page_break: assert property (
        (ce_i && q.st == S_PGOPEN && other_access_i)
        |=> (q.st == S_IDLE && pins_o.chip_select_n == 6'h3f))
        else $error("page not broken by other access");

    chk_wp_keep: assert property (
        (ce_i && q.ack && avs_write_i && q.write_protect_enable && avs_address_i < CS_AREA_END)
        |=> $stable(q.cfg) && $stable(q.act))
        else $error("protected register was written");

    chk_wp_flag: assert property (
        (ce_i && q.ack && avs_write_i && q.write_protect_enable && avs_address_i < CS_AREA_END)
        |=> (q.viol && q.vsrc[7:0] == $past(avs_address_i)))
        else $error("violation not recorded");

    chk_wp_clear: assert property (
        (ce_i && q.ack && avs_read_i && avs_address_i == OFS_WPSR)
        |=> !q.viol)
        else $error("status read did not clear flag");

    chk_confirm_only: assert property (
        !(ce_i && q.ack && avs_write_i && avs_address_i < CS_AREA_END
          && bus_reg == IDX_MODE)
        |=> $stable(q.act))
        else $error("config applied without mode write");

    chk_setup_len: assert property (
        (ce_i && acc && q.st == S_IDLE && !pg_rd && !req_i.wr
         && req_i.cs < 3'(NUM_CS))
        |=> (q.cs_on == $past(rd_cs_setup) && !q.page))
        else $error("setup length decode wrong");

    chk_write_normal: assert property (
        (ce_i && acc && q.st == S_IDLE && req_i.wr) |=> !q.page)
        else $error("write used page timing");

    chk_lane_bits: assert property (
        (q.st == S_ACC) |-> ((q_mode[POS_BUS_WIDTH +: 2] != BUS_W16 || !pins_o.addr[0])
            && (q_mode[POS_BUS_WIDTH +: 2] != BUS_W32 || pins_o.addr[1:0] == 2'b00)))
        else $error("ignored lane address bits were driven");

    chk_miss_close: assert property (
        (ce_i && q.st == S_PGOPEN && req_valid_i && !acc)
        |=> (q.st == S_IDLE && !q.pg_open && pins_o.chip_select_n == 6'h3f))
        else $error("page miss did not close the page");

    chk_confirm_apply: assert property (
        (ce_i && q.ack && avs_write_i && !q.write_protect_enable && avs_address_i < CS_AREA_END
         && bus_reg == IDX_MODE) |=> (q.act == q.cfg))
        else $error("mode write did not apply configuration");

    chk_bus_answer: assert property (
        (ce_i && bus_req && !q.ack) |=> (q.ack && avs_readdata_o == $past(rd_mux)))
        else $error("register bus answer missing or wrong");

endmodule // smprc_ctrl

/* smprc_mem_model.sv */
module smprc_mem_model
    import smprc_pkg::*;
(
    input  wire logic   ref_clk_i,
    input  smprc_pins_s pins_i,
    output logic [31:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] last_q = 32'h0;
    logic        on;
    // Drives data only while selected and read strobe low; there is no wait pin at all
    assign on      = ~&pins_i.chip_select_n & ~pins_i.read_strobe_n;
    assign rdata_o = on ? {6'h29, pins_i.addr} : ~last_q;
    // A released bus shows the inverse of the last word driven
    always_ff @(posedge ref_clk_i) if (on) last_q <= rdata_o;
endmodule // smprc_mem_model

/* testbench.sv */
module testbench
    import smprc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic        req_valid_i = 0, other_access_i = 0;
    logic [7:0]  avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rsp_rdata_o, mem_rdata, rd;
    logic        avs_waitrequest_o, req_ready_o, rsp_valid_o;
    smprc_req_s  req_i = '0;
    smprc_pins_s pins_o;
    int          bad_count = 0, total_checks = 0, len, lo;
    logic [3:0]  bsel = 4'hc;
    logic [31:0] rv [4] = '{RST_SETUP, RST_PULSE, RST_CYCLE, RST_MODE};
    smprc_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .other_access_i(other_access_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .mem_rdata_i(mem_rdata), .pins_o(pins_o));
    smprc_mem_model u_mem (.ref_clk_i(ref_clk_i), .pins_i(pins_o), .rdata_o(mem_rdata));
    // Free running clock
    initial forever #2 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic give_up();
        bad_count++;
        report_and_stop();
    endtask
    // Avalon access, held until waitrequest is seen low at a falling edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        logic w;
        int   n;
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        for (n = 0; n < 20; n++) begin
            @(negedge ref_clk_i);
            w = avs_waitrequest_o;
            d = avs_readdata_o;
            @(posedge ref_clk_i);
            if (w === 1'b0) break;
        end
        if (n == 20) give_up();
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    // Memory request; len counts cycles to the response, lo the first chip select cycle
    task automatic mem(input logic wr, input logic [2:0] cs, input logic [25:0] a);
        logic w;
        int   n;
        @(posedge ref_clk_i);
        req_i <= '{wr: wr, cs: cs, addr: a, be: 4'h3, wdata: 32'(a) ^ 32'ha5a50000};
        req_valid_i <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge ref_clk_i);
            w = req_ready_o;
            @(posedge ref_clk_i);
            if (w === 1'b1) break;
        end
        if (n == 50) give_up();
        req_valid_i <= 1'b0;
        lo = 0;
        for (len = 1; len < 400; len++) begin
            @(negedge ref_clk_i);
            if (pins_o.chip_select_n[cs] === 1'b0) begin
                if (lo == 0) lo = len;
                check("read strobe", 32'(pins_o.read_strobe_n), 32'(wr));
                check("byte selects", 32'(pins_o.byte_sel_n), 32'(bsel));
                check("write strobe", 32'(pins_o.write_strobe_n), 32'(!wr));
                check("data enable", 32'(pins_o.data_oe), 32'(wr));
                if (wr) check("write data", pins_o.wdata, 32'(a) ^ 32'ha5a50000);
            end
            if (rsp_valid_o === 1'b1) break;
        end
        if (len == 400) give_up();
        rd = rsp_rdata_o;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic scn_reset_values();
        for (int i = 0; i < 6; i++) begin
            for (int j = 0; j < 4; j++) begin
                bus(1'b0, 8'(i * 16 + j * 4), 32'h0, rd);
                check("reset value", rd, rv[j]);
            end
        end
        bus(1'b0, 8'hc0, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
    endtask
    task automatic scn_protect();
        bus(1'b1, OFS_WPMR, 32'h1, rd);
        for (int j = 0; j < 4; j++) begin
            bus(1'b1, 8'(16 + j * 4), 32'hffffffff, rd);
            bus(1'b0, 8'(16 + j * 4), 32'h0, rd);
            check("refused write", rd, rv[j]);
            bus(1'b0, OFS_WPSR, 32'h0, rd);
            check("violation status", rd, 32'h1 | (32'(16 + j * 4) << POS_VSRC));
            bus(1'b0, OFS_WPSR, 32'h0, rd);
            check("flag cleared", 32'(rd[POS_VIOL]), 32'h0);
        end
        bus(1'b1, OFS_WPMR, 32'h0, rd);
    endtask
    task automatic scn_page();
        logic [25:0] pa [6] = '{26'h100, 26'h106, 26'h102, 26'h108, 26'h10b, 26'h10e};
        int          pl [6] = '{3, 6, 6, 3, 3, 3};
        bus(1'b1, 8'h20, 32'h0a0a0a0a, rd);
        bus(1'b1, 8'h24, 32'h02050101, rd);
        bus(1'b1, 8'h28, 32'h00200020, rd);
        mem(1'b0, 3'd2, 26'h100);
        check("unconfirmed timing", 32'(len), 32'd4);
        bus(1'b1, 8'h2c, 32'h11001000, rd);
        for (int k = 0; k < 6; k++) begin
            if (k == 4) begin
                @(posedge ref_clk_i);
                other_access_i <= 1'b1;
                @(posedge ref_clk_i);
                other_access_i <= 1'b0;
            end
            if (k == 5) begin
                mem(1'b0, 3'd3, 26'h10c);
                check("no page timing", 32'(len), 32'd4);
            end
            mem(1'b0, 3'd2, pa[k]);
            check("page timing", 32'(len), 32'(pl[k]));
            check("page data", rd, {6'h29, pa[k][25:1], 1'b0});
        end
    endtask
    task automatic scn_write_and_setup();
        mem(1'b1, 3'd2, 26'h110);
        check("write timing", 32'(len), 32'd33);
        bus(1'b1, 8'h40, 32'h21210000, rd);
        bus(1'b1, 8'h48, 32'h00820000, rd);
        bus(1'b1, 8'h4c, RST_MODE | (32'h1 << POS_BYTE_ACC), rd);
        bsel = 4'h0;
        mem(1'b0, 3'd4, 26'h0);
        check("long setup", 32'(lo), 32'd130);
        check("long cycle", 32'(len), 32'd259);
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        scn_reset_values();
        scn_protect();
        scn_page();
        scn_write_and_setup();
        report_and_stop();
    end
endmodule // testbench
